// File: core/uss_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module uss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   srst,
  // filling and draining sides
  uss_stream_if.snk   wr,
  uss_stream_if.src   rd
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [CW-1:0]               count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } uss_fifo_s;

  uss_fifo_s s_q;
  uss_fifo_s s_d;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("uss_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // storage, pointers and registered read stage
  // ----------------------------------------------------------------
  always_comb begin
    logic push;
    logic pop;
    push = wr.valid && (s_q.count != FULL_CNT);
    pop  = 1'b0;
    s_d  = s_q;
    if (s_q.out_valid && rd.ready) begin
      s_d.out_valid = 1'b0;
    end
    if ((!s_q.out_valid || rd.ready) && (s_q.count != '0)) begin
      pop           = 1'b1;
      s_d.out_data  = s_q.mem[s_q.rptr];
      s_d.out_valid = 1'b1;
      s_d.rptr      = s_q.rptr + PTR_ONE;
    end
    if (push) begin
      s_d.mem[s_q.wptr] = wr.data;
      s_d.wptr          = s_q.wptr + PTR_ONE;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + CNT_ONE;
    end else if (pop && !push) begin
      s_d.count = s_q.count - CNT_ONE;
    end
    if (srst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign wr.ready = (s_q.count != FULL_CNT);
  assign rd.valid = s_q.out_valid;
  assign rd.data  = s_q.out_data;

endmodule
`default_nettype wire

// File: core/uss_sync.sv
`timescale 1ns/1ps
`default_nettype none
module uss_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } uss_sync_s;

  uss_sync_s s_q;
  uss_sync_s s_d;

  generate
    if (W < 1) begin : g_chk
      $error("uss_sync: W must be at least 1");
    end
  endgenerate

  always_comb begin
    s_d.meta   = async_in;
    s_d.stable = s_q.meta;
    if (srst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign sync_out = s_q.stable;

endmodule
`default_nettype wire

// File: core/uss_top.sv
`timescale 1ns/1ps
`default_nettype none
module uss_top
  import uss_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // serial pins
  input  wire logic              serial_in_pin,
  input  wire logic              shift_clock_pin_in,
  output logic                   shift_clock_pin_out,
  output logic                   shift_clock_pin_oe_n,
  output logic                   data_out_pin,
  output logic                   data_out_pin_oe_n,
  output logic                   twowire_data_pin_out,
  output logic                   twowire_data_pin_oe_n,
  // configuration levels
  input  wire logic              wire_mode_select_hi,
  input  wire logic              wire_mode_select_lo,
  input  wire logic              clock_source_select_hi,
  input  wire logic              clock_edge_select_lo,
  input  wire logic              data_out_drive_en,
  input  wire logic              shift_clock_drive_en,
  input  wire logic              overflow_irq_en,
  input  wire logic              start_irq_en,
  // strobes and events
  input  wire logic              software_clock_strobe,
  input  wire logic              clock_pin_toggle_strobe,
  input  wire logic              timer_match_pulse,
  // software access
  input  wire logic              data_wr_en,
  input  wire logic [DATA_W-1:0] data_wr_value,
  input  wire logic              status_wr_en,
  input  wire logic              status_wr_overflow_clear,
  input  wire logic              status_wr_start_clear,
  input  wire logic [CNT_W-1:0]  status_wr_count,
  // status
  output logic [DATA_W-1:0]      shift_data_q,
  output logic [CNT_W-1:0]       count_q,
  output logic                   count_overflow_flag,
  output logic                   start_flag,
  output logic                   overflow_irq,
  output logic                   start_irq,
  // received bytes
  output logic                   rx_valid,
  output logic [DATA_W-1:0]      rx_data,
  input  wire logic              rx_ready,
  output logic                   rx_fifo_ready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] shreg;
    logic [CNT_W-1:0]  cnt;
    logic              ovf;
    logic              start;
    logic              sck_prev;
    logic              di_prev;
    logic              sck_tog;
    logic              latch_open;
    logic              latch;
    uss_hold_e         hold;
    logic              push_v;
    logic [DATA_W-1:0] push_data;
    logic              fifo_ready;
    logic              irq_ovf;
    logic              irq_start;
    logic              sck_out;
    logic              sck_oe_n;
    logic              do_out;
    logic              do_oe_n;
    logic              sda_oe_n;
  } uss_main_s;

  uss_main_s s_q;
  uss_main_s s_d;

  uss_stream_if #(.WIDTH(DATA_W)) fill_if ();
  uss_stream_if #(.WIDTH(DATA_W)) drain_if ();

  logic [1:0] pins_sync;
  logic       sck_s;
  logic       di_s;

  function automatic logic rose(input logic prev, input logic cur);
    return !prev && cur;
  endfunction

  function automatic logic fell(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two stages bound the link clock to core/4 for edge detection
  uss_sync #(.W(2)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({serial_in_pin, shift_clock_pin_in}),
    .sync_out (pins_sync)
  );

  assign sck_s = pins_sync[0];
  assign di_s  = pins_sync[1];

  // ----------------------------------------------------------------
  // received byte buffer
  // ----------------------------------------------------------------
  uss_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH_P)) u_fifo (
    .clk  (clk),
    .srst (srst),
    .wr   (fill_if),
    .rd   (drain_if)
  );

  assign fill_if.valid  = s_q.push_v;
  assign fill_if.data   = s_q.push_data;
  assign drain_if.ready = rx_ready;

  // ----------------------------------------------------------------
  // shift, count, latch and hold logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] wmode;
    logic       twowire;
    logic       sck_r;
    logic       sck_f;
    logic       ext_sample;
    logic       ext_change;
    logic       shift_ev;
    logic       cnt_ev;
    logic       wrap;
    logic       start_det;
    shift_ev   = 1'b0;
    cnt_ev     = 1'b0;
    wrap       = 1'b0;
    start_det  = 1'b0;
    wmode      = {wire_mode_select_hi, wire_mode_select_lo};
    twowire    = (wmode == WM_TWO) || (wmode == WM_TWO_HOLD);
    sck_r      = rose(s_q.sck_prev, sck_s);
    sck_f      = fell(s_q.sck_prev, sck_s);
    ext_sample = clock_edge_select_lo ? sck_f : sck_r;
    ext_change = clock_edge_select_lo ? sck_r : sck_f;
    s_d          = s_q;
    s_d.sck_prev = sck_s;
    s_d.di_prev  = di_s;

    // clock source selection
    if (clock_source_select_hi) begin
      shift_ev = ext_sample;
    end else begin
      shift_ev = clock_edge_select_lo ? timer_match_pulse : software_clock_strobe;
    end
    if (!clock_source_select_hi) begin
      cnt_ev = shift_ev;
    end else if (software_clock_strobe) begin
      cnt_ev = clock_pin_toggle_strobe;
    end else begin
      cnt_ev = sck_r || sck_f;
    end

    // toggle strobe drives the shift clock pin level
    if (clock_pin_toggle_strobe) begin
      s_d.sck_tog = !s_q.sck_tog;
    end

    // shift register: software write wins over a shift
    if (data_wr_en) begin
      s_d.shreg = data_wr_value;
    end else if (shift_ev) begin
      s_d.shreg = {s_q.shreg[DATA_W-2:0], di_s};
    end

    // counter: status write wins over counting
    wrap = cnt_ev && (s_q.cnt == CNT_MAX) && !status_wr_en;
    if (status_wr_en) begin
      s_d.cnt = status_wr_count;
    end else if (cnt_ev) begin
      s_d.cnt = s_q.cnt + CNT_ONE;
    end
    if (status_wr_en && status_wr_overflow_clear) begin
      s_d.ovf = 1'b0;
    end
    if (wrap) begin
      s_d.ovf = 1'b1;
    end

    // output latch
    if (!clock_source_select_hi) begin
      s_d.latch_open = 1'b1;
    end else if (ext_sample) begin
      s_d.latch_open = 1'b0;
    end else if (ext_change) begin
      s_d.latch_open = 1'b1;
    end
    if (s_d.latch_open) begin
      s_d.latch = s_d.shreg[MSB_POS];
    end

    // two-wire start condition: data falls while clock high
    start_det = twowire && s_q.di_prev && !di_s && sck_s;
    if (status_wr_en && status_wr_start_clear) begin
      s_d.start = 1'b0;
    end
    if (start_det) begin
      s_d.start = 1'b1;
    end

    // completed byte goes to the buffer; a full buffer keeps it pending
    if (s_q.push_v && fill_if.ready) begin
      s_d.push_v = 1'b0;
    end
    if (wrap) begin
      s_d.push_v    = 1'b1;
      s_d.push_data = s_d.shreg;
    end
    s_d.fifo_ready = fill_if.ready;

    // two-wire clock hold
    case (s_q.hold)
      HOLD_FREE: begin
        if (start_det) begin
          s_d.hold = HOLD_START;
        end else if (twowire && wrap && ((wmode == WM_TWO_HOLD) || !fill_if.ready)) begin
          s_d.hold = HOLD_OVF;
        end
      end
      HOLD_START: begin
        if (!s_d.start) begin
          s_d.hold = HOLD_FREE;
        end
      end
      HOLD_OVF: begin
        if (!s_d.ovf && !s_d.push_v) begin
          s_d.hold = HOLD_FREE;
        end
      end
      default: begin
        s_d.hold = HOLD_FREE;
      end
    endcase
    if (!twowire) begin
      s_d.hold = HOLD_FREE;
    end

    // pin drivers: three-wire push-pull, two-wire open drain
    if (twowire) begin
      s_d.sck_out  = 1'b0;
      s_d.sck_oe_n = !((shift_clock_drive_en && !s_d.sck_tog)
                       || ((s_d.hold != HOLD_FREE) && !sck_s));
      s_d.do_out   = 1'b0;
      s_d.do_oe_n  = 1'b1;
      s_d.sda_oe_n = !(data_out_drive_en && !s_d.latch);
    end else begin
      s_d.sck_out  = s_d.sck_tog;
      s_d.sck_oe_n = !shift_clock_drive_en;
      s_d.do_out   = s_d.latch;
      s_d.do_oe_n  = !data_out_drive_en;
      s_d.sda_oe_n = 1'b1;
    end

    // interrupt requests
    s_d.irq_ovf   = s_d.ovf && overflow_irq_en;
    s_d.irq_start = s_d.start && start_irq_en;

    if (srst) begin
      s_d            = '0;
      s_d.shreg      = DATA_RST;
      s_d.cnt        = CNT_ZERO;
      s_d.hold       = HOLD_FREE;
      s_d.latch_open = 1'b1;
      s_d.sck_oe_n   = 1'b1;
      s_d.do_oe_n    = 1'b1;
      s_d.sda_oe_n   = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign shift_clock_pin_out   = s_q.sck_out;
  assign shift_clock_pin_oe_n  = s_q.sck_oe_n;
  assign data_out_pin          = s_q.do_out;
  assign data_out_pin_oe_n     = s_q.do_oe_n;
  assign twowire_data_pin_out  = 1'b0;
  assign twowire_data_pin_oe_n = s_q.sda_oe_n;
  assign shift_data_q          = s_q.shreg;
  assign count_q               = s_q.cnt;
  assign count_overflow_flag   = s_q.ovf;
  assign start_flag            = s_q.start;
  assign overflow_irq          = s_q.irq_ovf;
  assign start_irq             = s_q.irq_start;
  assign rx_valid              = drain_if.valid;
  assign rx_data               = drain_if.data;
  assign rx_fifo_ready         = s_q.fifo_ready;

endmodule
`default_nettype wire

// File: inc/uss_pkg.sv
`default_nettype none
package uss_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          DATA_W     = 8;
  localparam int          CNT_W      = 4;
  localparam int          FIFO_DEPTH = 8;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [3:0]  CNT_MAX    = 4'hF;
  localparam int          MSB_POS    = 7;

  // ----------------------------------------------------------------
  // wire modes {hi, lo}
  // ----------------------------------------------------------------
  localparam logic [1:0]  WM_OFF      = 2'h0;
  localparam logic [1:0]  WM_THREE    = 2'h1;
  localparam logic [1:0]  WM_TWO      = 2'h2;
  localparam logic [1:0]  WM_TWO_HOLD = 2'h3;

  // ----------------------------------------------------------------
  // link rate limits, in core clocks per link clock period
  // ----------------------------------------------------------------
  localparam int          SCK_DIV_MIN = 4;
  localparam int          SCL_DIV_MIN = 16;

  // ----------------------------------------------------------------
  // two-wire clock hold states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HOLD_FREE  = 3'h1,
    HOLD_START = 3'h2,
    HOLD_OVF   = 3'h4
  } uss_hold_e;

endpackage
`default_nettype wire

// File: inc/uss_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uss_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: verification/uss_chk.sv
`timescale 1ns/1ps
`default_nettype none
module uss_chk
  import uss_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              srst,
  // controls
  input wire logic              wire_mode_select_hi,
  input wire logic              wire_mode_select_lo,
  input wire logic              clock_source_select_hi,
  input wire logic              data_out_drive_en,
  input wire logic              overflow_irq_en,
  input wire logic              clock_pin_toggle_strobe,
  input wire logic              software_clock_strobe,
  input wire logic              data_wr_en,
  input wire logic [DATA_W-1:0] data_wr_value,
  input wire logic              status_wr_en,
  input wire logic              status_wr_overflow_clear,
  // observed
  input wire logic              shift_clock_pin_out,
  input wire logic              data_out_pin,
  input wire logic              data_out_pin_oe_n,
  input wire logic [DATA_W-1:0] shift_data_q,
  input wire logic [CNT_W-1:0]  count_q,
  input wire logic              count_overflow_flag,
  input wire logic              overflow_irq
);
  logic three;
  assign three = ({wire_mode_select_hi, wire_mode_select_lo} == WM_THREE);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_write_wins: assert property (data_wr_en |=> shift_data_q == $past(data_wr_value))
    else $error("shift data not taken from write");
  a_flag_clear: assert property (status_wr_en && status_wr_overflow_clear |=> !count_overflow_flag)
    else $error("overflow flag not cleared");
  a_wrap_flag: assert property ((count_q == CNT_MAX && !status_wr_en) ##1
    count_q == CNT_ZERO |-> count_overflow_flag)
    else $error("wrap without overflow flag");
  a_count_step: assert property (!status_wr_en |=> count_q == $past(count_q)
    || count_q == $past(count_q) + CNT_ONE)
    else $error("counter moved by more than one");
  // counting on the toggle strobe moves the counter apart from the shift
  a_shift_left: assert property (!data_wr_en && !status_wr_en
    && !(clock_source_select_hi && software_clock_strobe) ##1 shift_data_q != $past(shift_data_q)
    |-> shift_data_q[7:1] == $past(shift_data_q[6:0]) && count_q != $past(count_q))
    else $error("shift not a left shift with count");
  a_irq_follow: assert property (1'b1 |=> overflow_irq == (count_overflow_flag
    && $past(overflow_irq_en)))
    else $error("overflow irq not following flag");
  a_oe_three: assert property (three ##1 three |-> data_out_pin_oe_n == !$past(data_out_drive_en))
    else $error("data out enable wrong");
  a_latch_open: assert property ((three && !clock_source_select_hi) [*2]
    |-> data_out_pin == shift_data_q[MSB_POS])
    else $error("latch not transparent");
  a_pin_toggle: assert property (three && clock_pin_toggle_strobe
    |=> shift_clock_pin_out != $past(shift_clock_pin_out))
    else $error("clock pin did not toggle");
  c_overflow: cover property ($rose(count_overflow_flag));
  c_toggle: cover property (three && clock_pin_toggle_strobe);
  c_write: cover property (data_wr_en ##1 !data_wr_en);
endmodule
bind uss_top uss_chk u_chk (.clk, .srst, .wire_mode_select_hi, .wire_mode_select_lo,
  .clock_source_select_hi, .data_out_drive_en, .overflow_irq_en, .clock_pin_toggle_strobe,
  .software_clock_strobe,
  .data_wr_en, .data_wr_value, .status_wr_en, .status_wr_overflow_clear, .shift_clock_pin_out,
  .data_out_pin, .data_out_pin_oe_n, .shift_data_q, .count_q, .count_overflow_flag, .overflow_irq);
`default_nettype wire

// File: verification/uss_spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
module uss_spi_peer (
  // link wires
  input  wire logic miso,
  output var logic  sck,
  output var logic  mosi
);
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
  end
  // ----------------------------------------------------------------
  // one byte as master, clock idle low, msb first
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input logic m, input int h,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (!m) mosi = tx[i];
      #(h) sck = 1'b1;
      if (m) mosi = tx[i];
      else rx = {rx[6:0], miso};
      #(h) sck = 1'b0;
      if (m) rx = {rx[6:0], miso};
    end
    #(h) mosi = ~mosi;
  endtask
  // two-wire start: data falls while clock high
  task automatic start_cond(input int h);
    mosi = 1'b1;
    #(h) sck = 1'b1;
    #(h) mosi = 1'b0;
    #(h) sck = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verification/uss_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module uss_top_test;
  import uss_pkg::*;
  logic       clk, srst, wire_mode_select_hi, wire_mode_select_lo, clock_source_select_hi;
  logic       clock_edge_select_lo, data_out_drive_en, shift_clock_drive_en, overflow_irq_en;
  logic       start_irq_en, software_clock_strobe, clock_pin_toggle_strobe, timer_match_pulse;
  logic       data_wr_en, status_wr_en, status_wr_overflow_clear, status_wr_start_clear;
  logic       rx_ready, shift_clock_pin_out, shift_clock_pin_oe_n, data_out_pin;
  logic       data_out_pin_oe_n, count_overflow_flag, overflow_irq, rx_valid, rx_fifo_ready;
  logic [7:0] data_wr_value, shift_data_q, rx_data;
  logic [3:0] status_wr_count, count_q;
  logic       sck, start_flag, start_irq, twowire_data_pin_oe_n;
  wire logic  serial_in_pin;
  wire logic  shift_clock_pin_in;
  wire logic  miso;
  int         n_mismatch = 0;
  int         num_checks = 0;
  // shared clock wire and undriven data wire shows the inverse
  assign shift_clock_pin_in = !shift_clock_pin_oe_n ? shift_clock_pin_out : sck;
  assign miso = data_out_pin_oe_n ? ~data_out_pin : data_out_pin;
  uss_top DUT (.*, .twowire_data_pin_out());
  uss_spi_peer peer (.miso(miso), .sck(sck), .mosi(serial_in_pin));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic wait_for(ref logic s);
    cyc(1);
    for (int i = 0; i < 600 && s !== 1'b1; i++) cyc(1);
    if (s !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: wait timed out", $time);
      wrap_up();
    end
  endtask
  task automatic stat(input logic [3:0] c);
    status_wr_count = c;
    status_wr_overflow_clear = 1'b1;
    pulse(status_wr_en);
  endtask
  task automatic pop(input logic [7:0] e);
    wait_for(rx_valid);
    chk(rx_data, e);
    pulse(rx_ready);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_internal();
    logic s;
    s = serial_in_pin;
    wire_mode_select_lo = 1'b1;
    data_wr_value = 8'hA5;
    pulse(data_wr_en);
    stat(4'h0);
    repeat (8) pulse(software_clock_strobe);
    chk(shift_data_q, {8{s}});
    chk(8'(count_q), 8'h08);
    chk(8'(data_out_pin), 8'(s));
    pulse(timer_match_pulse);
    chk(8'(count_q), 8'h08);
    clock_edge_select_lo = 1'b1;
    data_wr_value = 8'h81;
    pulse(data_wr_en);
    pulse(timer_match_pulse);
    chk(shift_data_q, {7'h01, s});
    clock_edge_select_lo = 1'b0;
    data_wr_value = 8'h3C;
    data_wr_en = 1'b1;
    software_clock_strobe = 1'b1;
    cyc(1);
    data_wr_en = 1'b0;
    software_clock_strobe = 1'b0;
    cyc(1);
    chk(shift_data_q, 8'h3C);
    chk(8'(count_q), 8'h0A);
    overflow_irq_en = 1'b1;
    stat(4'hF);
    pulse(software_clock_strobe);
    chk(8'(count_q), 8'h00);
    chk(8'(count_overflow_flag), 8'h01);
    chk(8'(overflow_irq), 8'h01);
    stat(4'h0);
    chk(8'(count_overflow_flag), 8'h00);
    chk(8'(overflow_irq), 8'h00);
    pop({7'h3C, s});
  endtask
  task automatic t_toggle();
    logic s;
    s = serial_in_pin;
    clock_source_select_hi = 1'b1;
    software_clock_strobe = 1'b1;
    shift_clock_drive_en = 1'b1;
    data_wr_value = 8'h5A;
    pulse(data_wr_en);
    stat(4'h0);
    repeat (16) begin
      pulse(clock_pin_toggle_strobe);
      cyc(2);
    end
    chk(8'(count_q), 8'h00);
    chk(8'(count_overflow_flag), 8'h01);
    chk(shift_data_q, {8{s}});
    chk(8'(shift_clock_pin_out), 8'h00);
    pop({8{s}});
    software_clock_strobe = 1'b0;
    shift_clock_drive_en = 1'b0;
  endtask
  task automatic t_link(input logic m, input int h, input logic [7:0] tx,
                        input logic [7:0] dv);
    logic [7:0] rx;
    clock_edge_select_lo = m;
    data_out_drive_en = 1'b1;
    data_wr_value = dv;
    pulse(data_wr_en);
    stat(4'h0);
    peer.xfer(tx, m, h, rx);
    wait_for(count_overflow_flag);
    chk(shift_data_q, tx);
    chk(rx, dv);
    chk(8'(count_q), 8'h00);
    pop(tx);
  endtask
  task automatic t_fifo();
    logic       s;
    logic [7:0] v;
    s = serial_in_pin;
    clock_source_select_hi = 1'b0;
    clock_edge_select_lo = 1'b0;
    for (int i = 0; i < 9; i++) begin
      data_wr_value = 8'(i * 17);
      pulse(data_wr_en);
      stat(4'hF);
      pulse(software_clock_strobe);
    end
    cyc(1);
    chk(8'(rx_fifo_ready), 8'h00);
    for (int i = 0; i < 9; i++) begin
      v = 8'(i * 17);
      pop({v[6:0], s});
    end
    chk(8'(rx_fifo_ready), 8'h01);
  endtask
  task automatic t_two();
    wire_mode_select_hi = 1'b1;
    wire_mode_select_lo = 1'b0;
    start_irq_en = 1'b1;
    cyc(2);
    chk(8'(twowire_data_pin_oe_n), 8'h00);
    peer.start_cond(80);
    cyc(4);
    chk(8'(start_flag), 8'h01);
    chk(8'(start_irq), 8'h01);
    chk(8'(shift_clock_pin_oe_n), 8'h00);
    status_wr_start_clear = 1'b1;
    stat(4'h0);
    chk(8'(start_flag), 8'h00);
    chk(8'(start_irq), 8'h00);
    chk(8'(shift_clock_pin_oe_n), 8'h01);
  endtask
  initial begin
    srst = 1'b1;
    {wire_mode_select_hi, wire_mode_select_lo, clock_source_select_hi} = 3'h0;
    {clock_edge_select_lo, data_out_drive_en, shift_clock_drive_en} = 3'h0;
    {overflow_irq_en, start_irq_en, software_clock_strobe, clock_pin_toggle_strobe} = 4'h0;
    {timer_match_pulse, data_wr_en, status_wr_en, status_wr_overflow_clear} = 4'h0;
    {status_wr_start_clear, rx_ready} = 2'h0;
    data_wr_value = 8'h00;
    status_wr_count = 4'h0;
    cyc(20);
    srst = 1'b0;
    cyc(2);
    t_internal();
    t_toggle();
    t_link(1'b0, 80, 8'hC3, 8'h96);
    t_link(1'b1, 200, 8'h2D, 8'hE1);
    t_fifo();
    t_two();
    wrap_up();
  end
endmodule
`default_nettype wire
